// ### logic/ieee488_ctl_consts.svh
// Constants for the IEEE 488 controller control block.
`ifndef IEEE488_CTL_CONSTS_SVH
`define IEEE488_CTL_CONSTS_SVH
// ===========================================================================
// Register byte offsets.
`define REG_SYSCTL      8'h00
`define REG_IFC         8'h04
`define REG_REN         8'h08
`define REG_TMO         8'h0C
`define REG_SAD         8'h10
`define REG_PAD         8'h14
`define REG_TRG         8'h18
`define REG_EVMASK      8'h1C
`define REG_EVPEND      8'h20
`define REG_STATUS      8'h24
`define REG_RESULT      8'h28
// ===========================================================================
// Write data fields and result register error bits.
`define TGT_LSB         8
`define TGT_MSB         10
`define RES_ERR_NOSC    8
`define RES_ERR_BUS     9
`define RES_ERR_ARG     10
// ===========================================================================
// Status word bit positions.
`define ST_ERR          15
`define ST_SERVICE_REQUEST_EVENT         12
`define ST_LOK          7
`define ST_REM          6
`define ST_CIC          5
`define ST_ATN          4
`define ST_TACS         3
`define ST_LACS         2
`define ST_DTAS         1
`define ST_DCAS         0
`define EV_BOTH_MASK    16'h00EC
`define EV_RISE_MASK    16'h1003
// ===========================================================================
// Interface clear and secondary address codes.
`define IFC_CODE_OFF    8'h00
`define IFC_CODE_HOLD   8'h02
`define SAD_OFF_HI      7'h7F
`define SAD_MIN         7'h60
`define SAD_MAX         7'h7E
// ===========================================================================
// Bus command bytes.
`define CMD_TALK_BASE   8'h40
`define CMD_LISTEN_BASE 8'h20
`define CMD_UNLISTEN    8'h3F
`define CMD_TRIGGER     8'h08
// ===========================================================================
// Reset values.
`define RST_MASK        16'h0000
`define RST_TMO         4'hD
`define RST_SYSCTL      1'b1
// ===========================================================================
// Timing.
`define CLK_PERIOD_NS   10
`define IFC_MIN_US      100
`define IFC_CYCLES      ((`IFC_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TMO_TICK_US     10
`define TMO_TICK_CYCLES ((`TMO_TICK_US * 1000) / `CLK_PERIOD_NS)
`define TMO_DECADE      24'h00000A
`define TMO_STEP3       24'h000003
`endif

// ### logic/ieee488_ctl_pkg.sv
// Types shared by the IEEE 488 controller control block.
package ieee488_ctl_pkg;
  // =========================================================================
  // Main sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_IFC, ST_TRG} ctl_state_t;

  // =========================================================================
  // Time limit counter state.
  typedef struct packed {
    logic [15:0] div;
    logic [23:0] left;
    logic        run;
    logic        expired;
  } tmr_state_t;

  // =========================================================================
  // Controller state.
  typedef struct packed {
    ctl_state_t       state;
    logic             sys_ctl;
    logic             ifc;
    logic             ifc_hold;
    logic [19:0]      ifc_cnt;
    logic             cic;
    logic             atn;
    logic             ren;
    logic [15:0]      ev_mask;
    logic [15:0]      ev_pend;
    logic [15:0]      st_prev;
    logic             notify;
    logic [7:0][3:0]  tmo;
    logic [7:0][6:0]  sad;
    logic [7:0][4:0]  pad;
    logic [2:0]       sel;
    logic [2:0]       trg_tgt;
    logic [2:0]       step;
    logic             cmd_valid;
    logic [7:0]       cmd_byte;
    logic             tmr_start;
    logic             tmr_stop;
    logic [7:0]       prev_val;
    logic [2:0]       err;
    logic [31:0]      rdata;
  } ctl_regs_t;
endpackage

// ### logic/ieee488_tmo_timer.sv
// Operation time limit counter with its own 10 us tick divider.
`timescale 1ns/1ns
`include "ieee488_ctl_consts.svh"
module ieee488_tmo_timer
  import ieee488_ctl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TMO_TICK_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [23:0] limit,
  output logic             expired
);
  tmr_state_t t_reg;
  tmr_state_t t_next;

  // Start reloads the divider too, so no operation inherits a partial tick.
  always_comb
  begin
    t_next = t_reg;
    if (start)
    begin
      t_next.div     = 16'(TICK_CYCLES - 1);
      t_next.left    = limit;
      t_next.run     = (limit != 24'h000000);
      t_next.expired = 1'b0;
    end
    else if (stop)
    begin
      t_next.run     = 1'b0;
      t_next.expired = 1'b0;
    end
    else if (t_reg.run)
    begin
      if (t_reg.div == 16'h0000)
      begin
        t_next.div = 16'(TICK_CYCLES - 1);
        if (t_reg.left == 24'h000001)
        begin
          t_next.run     = 1'b0;
          t_next.expired = 1'b1;
        end
        else
        begin
          t_next.left = t_reg.left - 24'h000001;
        end
      end
      else
      begin
        t_next.div = t_reg.div - 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign expired = t_reg.expired;
endmodule

// ### logic/ieee488_ctl.sv
// IEEE 488 controller control: IFC, REN, events, time limits and trigger.
//
// Functional notes
// - Secondary value 0 or 7F disables.
// - Values 60..7E enable; sent after primary.
// - Mask bits request notifications; zero disables.
// - Mask bits follow status word layout.
// - Most states notify on entry and exit.
// - IFC pulse at least 100 us, system controller.
// - After IFC pulse: CIC, active, ATN.
// - IFC code 2 holds, 0 releases.
// - IFC refused without system control.
// - REN follows nonzero or zero argument.
// - REN refused without system control.
// - REN request returns previous REN state.
// - Time codes map 10 us to 100 s.
// - Unaccepted command bytes abort with bus error.
// - Time change returns previous code.
// - Separate time limit per target.
// - Trigger sends fixed address and GET sequence.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "ieee488_ctl_consts.svh"
module ieee488_ctl
  import ieee488_ctl_pkg::*;
#(
  parameter int unsigned IFC_CYCLES  = `IFC_CYCLES,
  parameter int unsigned TICK_CYCLES = `TMO_TICK_CYCLES
)
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        TALKER_ACTIVE,
  input  wire logic        LISTENER_ACTIVE,
  input  wire logic        TRIGGER_STATE,
  input  wire logic        CLEAR_STATE,
  input  wire logic        LOCKOUT_STATE_FLAG,
  input  wire logic        REMOTE_STATE_FLAG,
  input  wire logic        SERVICE_REQUEST_EVENT,
  output logic             IFC_OUT,
  output logic             REN_OUT,
  output logic             ATN_OUT,
  output logic             CMD_VALID,
  output logic [7:0]       CMD_BYTE,
  input  wire logic        CMD_ACCEPT,
  output logic             NOTIFY
);
  // =========================================================================
  // Reset synchroniser.
  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  ctl_regs_t   st_reg;
  ctl_regs_t   st_next;
  logic        tmr_expired;
  logic        access;
  logic        wr_go;
  logic        mapped;
  logic        busy;
  logic [15:0] stat_now;
  logic [15:0] ev_raw;
  logic [2:0]  wtgt;
  logic [6:0]  wsad;
  logic [2:0]  nstep;

  // Release is delayed by two flops; assertion stays asynchronous.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // =========================================================================
  // Helper functions.
  // Minimum time in 10 us ticks, 1-3 steps per decade.
  function automatic logic [23:0] tmo_ticks(input logic [3:0] code);
    logic [23:0] t;
    logic [3:0]  dec;
    t   = code[0] ? 24'h000001 : `TMO_STEP3;
    dec = (code - 4'h1) >> 1;
    for (int i = 0; i < 7; i++)
      if (4'(i) < dec)
        t = 24'(t * `TMO_DECADE);
    if (code == 4'h0)
      t = 24'h000000;
    return t;
  endfunction

  // Command byte sent at a given trigger step.
  function automatic logic [7:0] trg_byte(input logic [2:0] s,
                                          input ctl_regs_t r);
    case (s)
      3'h0:    trg_byte = `CMD_TALK_BASE | {3'h0, r.pad[0]};
      3'h1:    trg_byte = {1'b0, r.sad[0]};
      3'h2:    trg_byte = `CMD_UNLISTEN;
      3'h3:    trg_byte = `CMD_LISTEN_BASE | {3'h0, r.pad[r.trg_tgt]};
      3'h4:    trg_byte = {1'b0, r.sad[r.trg_tgt]};
      default: trg_byte = `CMD_TRIGGER;
    endcase
  endfunction

  // Next trigger step; secondary steps are skipped when not in use.
  function automatic logic [2:0] trg_next(input logic [2:0] s,
                                          input ctl_regs_t r);
    logic [2:0] n;
    n = s + 3'h1;
    if ((n == 3'h1) && (r.sad[0] == 7'h00))
      n = 3'h2;
    if ((n == 3'h4) && (r.sad[r.trg_tgt] == 7'h00))
      n = 3'h5;
    return n;
  endfunction

  // =========================================================================
  // Bus decode and status word.
  assign access = PSEL && PENABLE;
  assign busy   = (st_reg.state != ST_IDLE);
  assign mapped = (PADDR[1:0] == 2'b00) && (PADDR <= `REG_RESULT);
  // Command writes stall while a pulse or trigger runs.
  assign PREADY = !(PSEL && PWRITE && busy &&
                    ((PADDR == `REG_IFC) || (PADDR == `REG_TRG)));
  assign wr_go   = access && PWRITE && PREADY && mapped;
  assign PSLVERR = access && !mapped;
  assign wtgt    = PWDATA[`TGT_MSB:`TGT_LSB];
  assign wsad    = PWDATA[6:0];
  assign nstep   = trg_next(st_reg.step, st_reg);

  // Status word in its published bit layout.
  always_comb
  begin
    stat_now            = 16'h0000;
    stat_now[`ST_ERR]   = (st_reg.err != 3'h0);
    stat_now[`ST_SERVICE_REQUEST_EVENT]  = SERVICE_REQUEST_EVENT;
    stat_now[`ST_LOK]   = LOCKOUT_STATE_FLAG;
    stat_now[`ST_REM]   = REMOTE_STATE_FLAG;
    stat_now[`ST_CIC]   = st_reg.cic;
    stat_now[`ST_ATN]   = st_reg.atn;
    stat_now[`ST_TACS]  = TALKER_ACTIVE;
    stat_now[`ST_LACS]  = LISTENER_ACTIVE;
    stat_now[`ST_DTAS]  = TRIGGER_STATE;
    stat_now[`ST_DCAS]  = CLEAR_STATE;
  end

  // Both edges for states except ATN (no event), rising edge only for request, trigger, clear.
  assign ev_raw = ((stat_now ^ st_reg.st_prev) & `EV_BOTH_MASK) |
                  (stat_now & ~st_reg.st_prev & `EV_RISE_MASK);

  // =========================================================================
  // Next state.
  always_comb
  begin
    st_next           = st_reg;
    st_next.tmr_start = 1'b0;
    st_next.tmr_stop  = 1'b0;
    st_next.st_prev   = stat_now;
    st_next.notify    = |(ev_raw & st_reg.ev_mask);
    // Set wins over a clear in the same cycle.
    st_next.ev_pend   = st_reg.ev_pend | (ev_raw & st_reg.ev_mask);
    if (wr_go && (PADDR == `REG_EVPEND))
      st_next.ev_pend = (st_reg.ev_pend & ~PWDATA[15:0]) |
                        (ev_raw & st_reg.ev_mask);
    // Read data is captured in the setup phase.
    if (PSEL && !PENABLE && !PWRITE)
    begin
      case (PADDR)
        `REG_SYSCTL: st_next.rdata = {31'h0, st_reg.sys_ctl};
        `REG_IFC:    st_next.rdata = {30'h0, st_reg.ifc_hold, st_reg.ifc};
        `REG_REN:    st_next.rdata = {31'h0, st_reg.ren};
        `REG_TMO:    st_next.rdata = {28'h0, st_reg.tmo[st_reg.sel]};
        `REG_SAD:    st_next.rdata = {25'h0, st_reg.sad[st_reg.sel]};
        `REG_PAD:    st_next.rdata = {27'h0, st_reg.pad[st_reg.sel]};
        `REG_TRG:    st_next.rdata = {29'h0, st_reg.step};
        `REG_EVMASK: st_next.rdata = {16'h0, st_reg.ev_mask};
        `REG_EVPEND: st_next.rdata = {16'h0, st_reg.ev_pend};
        `REG_STATUS: st_next.rdata = {15'h0, busy, stat_now};
        `REG_RESULT: st_next.rdata = {21'h0, st_reg.err, st_reg.prev_val};
        default:     st_next.rdata = 32'h0;
      endcase
    end
    // Register writes and command requests.
    if (wr_go)
    begin
      case (PADDR)
        `REG_SYSCTL: st_next.sys_ctl = PWDATA[0];
        `REG_EVMASK: st_next.ev_mask = PWDATA[15:0];
        `REG_IFC:
        begin
          st_next.err = 3'h0;
          if (!st_reg.sys_ctl)
            st_next.err[`RES_ERR_NOSC - 8] = 1'b1;
          else if (PWDATA[7:0] == `IFC_CODE_OFF)
          begin
            st_next.ifc      = 1'b0;
            st_next.ifc_hold = 1'b0;
            if (st_reg.ifc)
            begin
              st_next.cic = 1'b1;
              st_next.atn = 1'b1;
            end
          end
          else if (PWDATA[7:0] == `IFC_CODE_HOLD)
          begin
            st_next.ifc      = 1'b1;
            st_next.ifc_hold = 1'b1;
          end
          else
          begin
            st_next.ifc      = 1'b1;
            st_next.ifc_hold = 1'b0;
            st_next.ifc_cnt  = 20'(IFC_CYCLES - 1);
            st_next.state    = ST_IFC;
          end
        end
        `REG_REN:
        begin
          st_next.err = 3'h0;
          if (!st_reg.sys_ctl)
            st_next.err[`RES_ERR_NOSC - 8] = 1'b1;
          else
          begin
            st_next.prev_val = {7'h0, st_reg.ren};
            st_next.ren      = (PWDATA != 32'h0);
          end
        end
        `REG_TMO:
        begin
          st_next.err       = 3'h0;
          st_next.sel       = wtgt;
          st_next.prev_val  = {4'h0, st_reg.tmo[wtgt]};
          st_next.tmo[wtgt] = PWDATA[3:0];
        end
        `REG_SAD:
        begin
          st_next.err = 3'h0;
          st_next.sel = wtgt;
          if ((wsad == 7'h00) || (wsad == `SAD_OFF_HI) ||
              ((wsad >= `SAD_MIN) && (wsad <= `SAD_MAX)))
          begin
            st_next.prev_val  = {1'b0, st_reg.sad[wtgt]};
            // Zero in storage means secondary addressing is off.
            st_next.sad[wtgt] = (wsad == `SAD_OFF_HI) ? 7'h00 : wsad;
          end
          else
            st_next.err[`RES_ERR_ARG - 8] = 1'b1;
        end
        `REG_PAD:
        begin
          st_next.sel       = wtgt;
          st_next.pad[wtgt] = PWDATA[4:0];
        end
        `REG_TRG:
        begin
          st_next.err = 3'h0;
          if (wtgt == 3'h0)
            st_next.err[`RES_ERR_ARG - 8] = 1'b1;
          else
          begin
            st_next.trg_tgt   = wtgt;
            st_next.step      = 3'h0;
            st_next.state     = ST_TRG;
            st_next.tmr_start = 1'b1;
          end
        end
        default: st_next.err = st_reg.err;
      endcase
    end
    // Sequencer.
    case (st_reg.state)
      ST_IDLE: st_next.cmd_valid = 1'b0;
      ST_IFC:
      begin
        if (st_reg.ifc_cnt == 20'h0)
        begin
          st_next.ifc   = 1'b0;
          st_next.cic   = 1'b1;
          st_next.atn   = 1'b1;
          st_next.state = ST_IDLE;
        end
        else
          st_next.ifc_cnt = st_reg.ifc_cnt - 20'h1;
      end
      ST_TRG:
      begin
        if (!st_reg.cmd_valid && !st_reg.tmr_start)
        begin
          st_next.cmd_valid = 1'b1;
          st_next.cmd_byte  = trg_byte(st_reg.step, st_reg);
        end
        else if (st_reg.cmd_valid && CMD_ACCEPT)
        begin
          if (st_reg.step == 3'h5)
          begin
            st_next.cmd_valid = 1'b0;
            st_next.tmr_stop  = 1'b1;
            st_next.state     = ST_IDLE;
          end
          else
          begin
            st_next.step     = nstep;
            st_next.cmd_byte = trg_byte(nstep, st_reg);
          end
        end
        else if (tmr_expired)
        begin
          st_next.cmd_valid = 1'b0;
          st_next.err[`RES_ERR_BUS - 8] = 1'b1;
          st_next.tmr_stop  = 1'b1;
          st_next.state     = ST_IDLE;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
  end

  // State register; reset loads defaults for every target's time limit.
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg         <= '0;
      st_reg.state   <= ST_IDLE;
      st_reg.sys_ctl <= `RST_SYSCTL;
      st_reg.ev_mask <= `RST_MASK;
      st_reg.tmo     <= {8{`RST_TMO}};
    end
    else
      st_reg <= st_next;
  end

  // =========================================================================
  // Time limit counter for the running operation's target.
  ieee488_tmo_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk     (SYS_CLK),
    .rst_n   (rst_n),
    .start   (st_reg.tmr_start),
    .stop    (st_reg.tmr_stop),
    .limit   (tmo_ticks(st_reg.tmo[st_reg.trg_tgt])),
    .expired (tmr_expired)
  );

  // Outputs.
  assign PRDATA    = st_reg.rdata;
  assign IFC_OUT   = st_reg.ifc;
  assign REN_OUT   = st_reg.ren;
  assign ATN_OUT   = st_reg.atn;
  assign CMD_VALID = st_reg.cmd_valid;
  assign CMD_BYTE  = st_reg.cmd_byte;
  assign NOTIFY    = st_reg.notify;

  // =========================================================================
  // Assertions.
  logic [19:0] ifc_run;
  logic        w_ifc;
  logic        w_ren;

  // Counts consecutive cycles of IFC high.
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      ifc_run <= 20'h0;
    else
      ifc_run <= IFC_OUT ? ifc_run + 20'h1 : 20'h0;
  end
  assign w_ifc = wr_go && (PADDR == `REG_IFC);
  assign w_ren = wr_go && (PADDR == `REG_REN);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  a_ifc_min_width: assert property ($fell(IFC_OUT) && !$past(st_reg.ifc_hold)
    && !$past(w_ifc) |-> ifc_run >= 20'(IFC_CYCLES))
    else $error("IFC pulse shorter than minimum");
  a_ifc_cic_after: assert property ($fell(IFC_OUT) |->
    stat_now[`ST_CIC] && ATN_OUT)
    else $error("no CIC and ATN after IFC");
  a_ifc_refused: assert property (w_ifc && !st_reg.sys_ctl |=>
    st_reg.err[0] && $stable(IFC_OUT))
    else $error("IFC request not refused");
  a_ifc_hold: assert property (w_ifc && st_reg.sys_ctl &&
    PWDATA[7:0] == `IFC_CODE_HOLD |=> IFC_OUT [*8])
    else $error("IFC hold released");
  a_ren_follow: assert property (w_ren && st_reg.sys_ctl |=>
    REN_OUT == ($past(PWDATA) != 32'h0))
    else $error("REN does not follow argument");
  a_ren_refused: assert property (w_ren && !st_reg.sys_ctl |=>
    $stable(REN_OUT) && st_reg.err[0])
    else $error("REN request not refused");
  a_ren_prev: assert property (w_ren && st_reg.sys_ctl |=>
    st_reg.prev_val[0] == $past(REN_OUT))
    else $error("previous REN not returned");
  a_tmo_prev: assert property (wr_go && PADDR == `REG_TMO |=>
    st_reg.prev_val[3:0] == $past(st_reg.tmo[wtgt]))
    else $error("previous time code not returned");
  a_sad_off: assert property (wr_go && PADDR == `REG_SAD &&
    (wsad == 7'h00 || wsad == `SAD_OFF_HI) |=>
    st_reg.sad[st_reg.sel] == 7'h00)
    else $error("secondary addressing not disabled");
  a_mask_zero: assert property (st_reg.ev_mask == 16'h0 |=> !NOTIFY)
    else $error("notification with empty mask");
  a_state_edge: assert property ($changed(TALKER_ACTIVE) &&
    st_reg.ev_mask[`ST_TACS] |=> NOTIFY)
    else $error("talker change not notified");
  a_trg_first: assert property ($rose(st_reg.state == ST_TRG) |->
    ##[1:2] CMD_VALID && CMD_BYTE[7:5] == 3'h2)
    else $error("trigger did not start with talk address");
  a_tmo_abort: assert property (CMD_VALID && !CMD_ACCEPT && tmr_expired
    |=> !CMD_VALID && st_reg.err[1])
    else $error("unaccepted command not aborted");

  c_ifc_pulse: cover property ($fell(IFC_OUT) && st_reg.cic);
  c_trg_done: cover property (CMD_VALID && CMD_ACCEPT &&
    CMD_BYTE == `CMD_TRIGGER);
  c_tmo_abort: cover property (CMD_VALID && tmr_expired && !CMD_ACCEPT);
  c_notify: cover property (NOTIFY);
endmodule

// ### verif/instr_model.sv
// Bus instrument model that takes trigger command bytes.
`timescale 1ns/1ns
module instr_model
#(
  parameter logic [7:0] MY_LISTEN = 8'h27
)
(
  input  wire logic       clk,
  input  wire logic       hold,
  input  wire logic       ifc,
  input  wire logic       ren,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  output logic            cmd_accept
);
  logic [7:0] seen[$];
  logic       acc;
  logic       listen   = 1'b0;
  logic       remote   = 1'b0;
  logic       lockout  = 1'b0;
  int         trig_cnt = 0;
  initial cmd_accept = 1'b0;
  assign acc = cmd_valid && cmd_accept;
  // Slow listener: accepts every other cycle, never while held.
  always @(posedge clk)
  begin
    if (acc)
      seen.push_back(cmd_byte);
    cmd_accept <= cmd_valid && !hold && !cmd_accept;
  end
  // Interface clear drops addressing only; the trigger count survives it.
  always @(posedge clk)
  begin
    if (ifc)
      listen <= 1'b0;
    else if (acc && (cmd_byte == MY_LISTEN))
      listen <= 1'b1;
    else if (acc && (cmd_byte == 8'h3F))
      listen <= 1'b0;
    if (acc && (cmd_byte == 8'h08) && listen)
      trig_cnt <= trig_cnt + 1;
  end
  // Remote needs REN and our listen address; lockout holds until REN drops.
  always @(posedge clk)
  begin
    if (!ren)
      remote <= 1'b0;
    else if (acc && (cmd_byte == MY_LISTEN))
      remote <= 1'b1;
    if (!ren)
      lockout <= 1'b0;
    else if (acc && (cmd_byte == 8'h11))
      lockout <= 1'b1;
  end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the IEEE 488 controller control block.
`timescale 1ns/1ns
module tb_top;
  typedef struct packed
  {
    logic [7:0]  a;
    logic [31:0] w;
    logic [7:0]  ra;
    logic [31:0] e;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        hold = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [6:0]  bst = '0;
  logic [31:0] rd, prdata;
  logic        se, pready, pslverr, ifc, ren, atn, cv, ca, ntf;
  logic [7:0]  cb;
  int          failures = 0, n_compared = 0, ifc_n = 0, ntf_n = 0, b;
  int          ev_n[7] = '{2, 2, 1, 1, 2, 2, 1};
  logic [7:0]  cmd_exp[5] = '{8'h40, 8'h3F, 8'h27, 8'h65, 8'h08};
  row_t        rows[9] = '{
    '{8'h1C, 32'h0000_10EF, 8'h1C, 32'h0000_10EF},
    '{8'h0C, 32'h0000_0305, 8'h28, 32'h0000_000D},
    '{8'h0C, 32'h0000_0301, 8'h28, 32'h0000_0005},
    '{8'h0C, 32'h0000_0001, 8'h28, 32'h0000_000D},
    '{8'h10, 32'h0000_026A, 8'h28, 32'h0000_0000},
    '{8'h10, 32'h0000_027F, 8'h28, 32'h0000_006A},
    '{8'h10, 32'h0000_0265, 8'h28, 32'h0000_0000},
    '{8'h08, 32'h0000_0001, 8'h28, 32'h0000_0000},
    '{8'h08, 32'h0000_0000, 8'h28, 32'h0000_0001}};
  // ==========================================================================
  // Clock, event counters and instances.
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    ntf_n += ntf;
    ifc_n += ifc;
  end
  ieee488_ctl #(.IFC_CYCLES(20), .TICK_CYCLES(4)) dut_u
  (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TALKER_ACTIVE(bst[0]),
    .LISTENER_ACTIVE(bst[1]), .TRIGGER_STATE(bst[2]),
    .CLEAR_STATE(bst[3]), .LOCKOUT_STATE_FLAG(bst[4]),
    .REMOTE_STATE_FLAG(bst[5]), .SERVICE_REQUEST_EVENT(bst[6]),
    .IFC_OUT(ifc), .REN_OUT(ren), .ATN_OUT(atn), .CMD_VALID(cv),
    .CMD_BYTE(cb), .CMD_ACCEPT(ca), .NOTIFY(ntf)
  );
  instr_model inst_u
  (
    .clk(clk), .hold(hold), .ifc(ifc), .ren(ren), .cmd_valid(cv),
    .cmd_byte(cb), .cmd_accept(ca)
  );
  // ==========================================================================
  // Bus cycle, compare and verdict tasks.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial
  begin
    #500000;
    failures++;
    tally_and_finish();
  end
  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h0C, '0);
    chk("tmo rst", rd, 32'h0000_000D);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].ra, '0);
      chk("row", rd, rows[i].e);
    end
    for (int i = 0; i < 7; i++)
    begin
      b = ntf_n;
      bst[i] <= 1'b1;
      repeat (4) @(posedge clk);
      bst[i] <= 1'b0;
      repeat (4) @(posedge clk);
      chk("notify", ntf_n - b, ev_n[i]);
    end
    apb(1'b1, 8'h1C, '0);
    b = ntf_n;
    bst[0] <= 1'b1;
    repeat (4) @(posedge clk);
    chk("masked", ntf_n - b, 0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    chk("remote pre", inst_u.remote, 1'b0);
    apb(1'b1, 8'h14, 32'h0000_0207);
    apb(1'b1, 8'h18, 32'h0000_0200);
    for (b = 0; b < 200 && inst_u.seen.size() < 5; b++)
      @(posedge clk);
    foreach (cmd_exp[i])
      chk("cmd", inst_u.seen[i], cmd_exp[i]);
    chk("remote", inst_u.remote, 1'b1);
    apb(1'b1, 8'h0C, 32'h0000_0201);
    hold <= 1'b1;
    apb(1'b1, 8'h18, 32'h0000_0200);
    repeat (30) @(posedge clk);
    chk("cmd_valid", cv, 1'b0);
    apb(1'b0, 8'h28, '0);
    chk("bus err", rd[9], 1'b1);
    hold <= 1'b0;
    b = ifc_n;
    apb(1'b1, 8'h04, 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk("ifc len", ifc_n - b, 20);
    chk("atn", atn, 1'b1);
    apb(1'b0, 8'h24, '0);
    chk("cic", rd[5], 1'b1);
    chk("unlisten", inst_u.listen, 1'b0);
    chk("dev kept", inst_u.trig_cnt, 1);
    apb(1'b1, 8'h04, 32'h0000_0002);
    repeat (40) @(posedge clk);
    chk("hold", ifc, 1'b1);
    apb(1'b1, 8'h04, '0);
    chk("release", ifc, 1'b0);
    apb(1'b1, 8'h00, '0);
    apb(1'b1, 8'h04, 32'h0000_0001);
    chk("ifc off", ifc, 1'b0);
    apb(1'b0, 8'h28, '0);
    chk("nosc", rd[8], 1'b1);
    apb(1'b1, 8'h08, '0);
    chk("ren kept", ren, 1'b1);
    apb(1'b0, 8'h28, '0);
    chk("nosc", rd[8], 1'b1);
    apb(1'b0, 8'h2C, '0);
    chk("slverr", se, 1'b1);
    tally_and_finish();
  end
endmodule
